//--- shared/eps_defines.svh
// Register offsets, reset values, limits and timing for the position core
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// Byte addresses of the register words
`define EPS_REG_CTRL 6'h00
`define EPS_REG_LEN 6'h04
`define EPS_REG_NUM 6'h08
`define EPS_REG_DEN 6'h0C
`define EPS_REG_PRE1 6'h10
`define EPS_REG_PRE2 6'h14
`define EPS_REG_LIMLO 6'h18
`define EPS_REG_LIMHI 6'h1C
`define EPS_REG_MULT 6'h20
`define EPS_REG_STAT 6'h24
`define EPS_REG_POS 6'h28
`define EPS_REG_IPR 6'h2C
`define EPS_REG_SHIFT 6'h30

// Status register bit positions
`define EPS_STAT_LIMIT 0
`define EPS_STAT_BUSY 1
`define EPS_STAT_REFUSED 2

// Reset values
`define EPS_RST_CTRL 15'h3001
`define EPS_RST_LEN 32'h0000_1000
`define EPS_RST_NUM 32'h0000_0001
`define EPS_RST_DEN 32'h0000_0001
`define EPS_RST_PRESET 32'h0000_0000
`define EPS_RST_LIMLO 32'h0000_0000
`define EPS_RST_LIMHI 32'h00FF_FFFF
`define EPS_RST_MULT 7'h01

// Accepted ranges
`define EPS_DEN_MAX 32'h0000_FFFF
`define EPS_LEN_MIN 32'h0000_0005
`define EPS_MULT_MAX 7'h64
`define EPS_SSI_MIN 6'h08
`define EPS_SSI_MAX 6'h20
`define EPS_RAW_TURNS 32'h0001_0000

// Diagnostic lengths in bytes, 6+51 and 6+10
`define EPS_DIAG_LONG 8'h39
`define EPS_DIAG_SHORT 8'h10

// Timing
`define EPS_CLK_HZ 100000000
`define EPS_PRESET_MS 30
`define EPS_PRESET_CYC (`EPS_PRESET_MS * (`EPS_CLK_HZ / 1000))

`endif

//--- shared/eps_pkg.sv
// Types shared by the position core
package eps_pkg;

   typedef enum logic [1:0] {EPS_CODE_GRAY, EPS_CODE_BIN,
      EPS_CODE_SHGRAY} eps_code_type;

   typedef enum logic [1:0] {EPS_COMM_OFF_NOSTAT, EPS_COMM_OFF_STAT,
      EPS_COMM_ON_STAT} eps_comm_type;

   typedef enum logic [1:0] {EPS_PF_IDLE, EPS_PF_HOLD, EPS_PF_WAIT_LOW,
      EPS_PF_SETTLE} eps_pf_state_type;

   typedef struct packed {
      logic [5:0] ssi_bits;
      eps_comm_type commission;
      logic short_diag;
      logic ext_mode;
      logic ccw;
      eps_code_type ssi_code;
      eps_code_type bus_code;
   } eps_ctrl_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
   } eps_avs_req_type;

endpackage

//--- tb/encoder_position_scaling_preset_tb.sv
// Self-checking bench for the position core
`timescale 1ns/10ps
`default_nettype none
`include "eps_defines.svh"
module encoder_position_scaling_preset_tb;
   import eps_pkg::*;
   localparam int unsigned W = 8;
   logic i_mclk, i_rst_n, i_step, i_step_cw, i_preset1, i_preset2, wrq, lim;
   logic nvs;
   logic signed [15:0] i_rpm;
   eps_avs_req_type i_avs;
   logic [31:0] rdata, pos_word, speed, q, ssi_word, nvsh;
   logic [7:0] diag_len;
   logic [15:0] lfsr;
   logic [6:0] mult;
   logic [31:0] rst_a[6] = '{0, 16, 20, 24, 28, 32};
   logic [31:0] rst_v[6] = '{'h3001, 0, 0, 0, 'hFF_FFFF, 1};
   logic [31:0] lo_t[4] = '{200, 100, 100, 250};
   logic [31:0] hi_t[4] = '{300, 300, 150, 300};
   logic [3:0] lb_t = 4'b1101;
   int n_mismatch = 0;
   int check_count = 0;
   eps_core #(.PRESET_CYC(W)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_avs(i_avs), .o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
      .i_step(i_step), .i_step_cw(i_step_cw), .i_rpm(i_rpm),
      .i_preset1(i_preset1), .i_preset2(i_preset2), .o_pos_word(pos_word),
      .o_limit_bit(lim), .o_speed(speed), .o_diag_len(diag_len),
      .o_ssi_word(ssi_word), .o_nv_store(nvs), .o_nv_zero(),
      .o_nv_shift(nvsh));
   eps_master_model bus (.i_mclk(i_mclk), .i_waitrequest(wrq),
      .i_readdata(rdata), .o_avs(i_avs), .o_preset1(i_preset1),
      .o_preset2(i_preset2));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] exp_speed(input logic signed [15:0] r,
      input logic [6:0] m);
      logic signed [31:0] t;
      t = r;
      return t * $signed({25'h000_0000, m});
   endfunction
   function automatic logic [31:0] gray(input logic [31:0] b);
      return b ^ (b >> 1);
   endfunction
   // Offset centres the length in the next power of two
   function automatic logic [31:0] sh_gray(input logic [31:0] b,
      input logic [31:0] len);
      logic [32:0] p;
      p = 33'h0_0000_0001;
      while (p < {1'b0, len}) p = p << 1;
      return gray(b + 32'((p - {1'b0, len}) >> 1));
   endfunction
   task automatic wait_div();
      bus.xfer(0, `EPS_REG_STAT, '0, q);
      for (int i = 0; i < 60 && q[1]; i++)
         bus.xfer(0, `EPS_REG_STAT, '0, q);
      chk(32'(q[1]), 32'h0000_0000);
   endtask
   task automatic steps(input int n);
      i_step <= 1'b1;
      repeat (n) @(posedge i_mclk);
      i_step <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   initial begin
      #(30000 * 10);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      i_rst_n = 1'b0;
      i_step = 1'b0;
      i_step_cw = 1'b1;
      i_rpm = 16'h0000;
      lfsr = 16'h1B81;
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      chk(32'(diag_len), 32'(`EPS_DIAG_LONG));
      for (int i = 0; i < 6; i++) begin
         bus.xfer(0, rst_a[i][5:0], '0, q);
         chk(q, rst_v[i]);
      end
      bus.xfer(0, 6'h3C, '0, q);
      chk(q, 32'h0000_0000);
      // Divider busy after reset; bounded poll
      wait_div();
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         mult = (i == 0) ? 7'h64 : 7'(lfsr[7:0] % 100) + 7'h01;
         bus.xfer(1, `EPS_REG_MULT, 32'(mult), q);
         i_rpm <= lfsr;
         repeat (2) @(posedge i_mclk);
         chk(speed, exp_speed(lfsr, mult));
      end
      bus.xfer(1, `EPS_REG_MULT, 32'h0000_0065, q);
      bus.xfer(0, `EPS_REG_MULT, '0, q);
      chk(q, 32'(mult));
      bus.xfer(1, `EPS_REG_CTRL, 32'h0000_3081, q);
      bus.xfer(0, `EPS_REG_STAT, '0, q);
      chk(32'(q[2]), 32'h0000_0001);
      bus.xfer(0, `EPS_REG_CTRL, '0, q);
      chk(q, 32'h0000_3001);
      // Presets kept below the 4096 length, one revolution
      bus.xfer(1, `EPS_REG_PRE1, 32'h0000_0064, q);
      bus.xfer(1, `EPS_REG_PRE2, 32'h0000_00C8, q);
      bus.pulse(0, W - 3);
      repeat (3) @(posedge i_mclk);
      chk(pos_word, 32'h0000_0000);
      bus.pulse(0, W + 4);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, 32'h0000_0064);
      // Re-rise inside the settle time must be ignored
      bus.xfer(1, `EPS_REG_PRE1, 32'h0000_012C, q);
      bus.pulse(0, 3 * W);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, 32'h0000_0064);
      repeat (W + 4) @(posedge i_mclk);
      bus.pulse(1, W + 4);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, 32'h0000_00C8);
      for (int i = 0; i < 4; i++) begin
         bus.xfer(1, `EPS_REG_LIMLO, lo_t[i], q);
         bus.xfer(1, `EPS_REG_LIMHI, hi_t[i], q);
         bus.xfer(0, `EPS_REG_STAT, '0, q);
         chk(32'(q[0]), 32'(lb_t[i]));
         chk(32'(lim), 32'h0000_0000);
      end
      // 4096 per turn: 16 raw steps per increment
      steps(32);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, 32'h0000_00CA);
      bus.xfer(1, `EPS_REG_CTRL, 32'h0000_3011, q);
      wait_div();
      steps(32);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, 32'h0000_00C8);
      bus.xfer(1, `EPS_REG_CTRL, 32'h0000_3000, q);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, gray(32'h0000_00C8));
      chk(ssi_word, gray(32'h0000_00C8) << 8);
      bus.xfer(1, `EPS_REG_LEN, 32'h0000_0E10, q);
      bus.xfer(1, `EPS_REG_CTRL, 32'h0000_300A, q);
      repeat (2) @(posedge i_mclk);
      chk(pos_word, sh_gray(32'h0000_00C8, 32'h0000_0E10));
      chk(ssi_word, sh_gray(32'h0000_00C8, 32'h0000_0E10) << 8);
      // Three turns do not divide the raw span; a wrap moves the mark
      bus.xfer(1, `EPS_REG_NUM, 32'h0000_0003, q);
      wait_div();
      i_step_cw <= 1'b0;
      steps(1);
      @(negedge i_mclk);
      chk(32'(nvs), 32'h0000_0001);
      @(posedge i_mclk);
      chk(nvsh, 32'hFFFF_FFFF);
      bus.xfer(1, `EPS_REG_DEN, 32'h0001_0000, q);
      bus.xfer(0, `EPS_REG_STAT, '0, q);
      chk(32'(q[2]), 32'h0000_0001);
      bus.xfer(0, `EPS_REG_DEN, '0, q);
      chk(q, 32'h0000_0001);
      bus.xfer(1, `EPS_REG_CTRL, 32'h0000_3061, q);
      repeat (2) @(posedge i_mclk);
      chk(32'(diag_len), 32'(`EPS_DIAG_SHORT));
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- tb/eps_master_model.sv
// Fieldbus master model: register bus and preset pins
`timescale 1ns/10ps
`default_nettype none
module eps_master_model (
   // Clock and bus answer
   input wire logic i_mclk,
   input wire logic i_waitrequest,
   input wire logic [31:0] i_readdata,
   // Requests and preset pins
   output var eps_pkg::eps_avs_req_type o_avs,
   output var logic o_preset1,
   output var logic o_preset2
);
   import eps_pkg::*;
   initial begin
      o_avs = '0;
      o_preset1 = 1'b0;
      o_preset2 = 1'b0;
   end
   // Request held until waitrequest is seen low at an edge
   task automatic xfer(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
      o_avs <= '{read: !w, write: w, address: a, writedata: d};
      do @(posedge i_mclk); while (i_waitrequest);
      q = i_readdata;
      o_avs <= '0;
      @(posedge i_mclk);
   endtask
   // Pin high for n cycles; callers keep values below length
   task automatic pulse(input logic sel, input int n);
      if (sel) o_preset2 <= 1'b1;
      else o_preset1 <= 1'b1;
      repeat (n) @(posedge i_mclk);
      o_preset1 <= 1'b0;
      o_preset2 <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verilog/eps_core.sv
// Encoder position scaling, preset filtering, limits and code output
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "eps_defines.svh"

// Filters one preset input and fires once per accepted hold
module eps_preset_filt #(
   parameter int unsigned WIN_CYC = `EPS_PRESET_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Preset pin level
   input wire logic i_level,
   // Accepted preset
   output logic o_fire
);
   import eps_pkg::*;
   localparam int CW = $clog2(WIN_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(WIN_CYC - 1);

   eps_pf_state_type state_r;
   logic [CW-1:0] cnt_r;
   logic lvl_d_r;
   logic [31:0] run_r;

   generate
      if (WIN_CYC < 2) begin : g_bad
         $error("preset window must be at least two cycles");
      end
   endgenerate

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lvl_d_r <= 1'b1;
      end else begin
         lvl_d_r <= i_level;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= EPS_PF_IDLE;
         cnt_r <= '0;
         o_fire <= 1'b0;
      end else begin
         o_fire <= 1'b0;
         case (state_r)
            EPS_PF_IDLE: begin
               if (i_level && !lvl_d_r) begin
                  state_r <= EPS_PF_HOLD;
                  cnt_r <= CW'(1);
               end
            end
            EPS_PF_HOLD: begin
               // Any drop inside the window cancels the preset
               if (!i_level) begin
                  state_r <= EPS_PF_IDLE;
               end else if (cnt_r == LAST) begin
                  o_fire <= 1'b1;
                  state_r <= EPS_PF_WAIT_LOW;
               end else begin
                  cnt_r <= cnt_r + CW'(1);
               end
            end
            EPS_PF_WAIT_LOW: begin
               if (!i_level) begin
                  state_r <= EPS_PF_SETTLE;
                  cnt_r <= '0;
               end
            end
            EPS_PF_SETTLE: begin
               // A level still high here is no new edge
               if (cnt_r == LAST) begin
                  state_r <= EPS_PF_IDLE;
               end else begin
                  cnt_r <= cnt_r + CW'(1);
               end
            end
            default: state_r <= EPS_PF_IDLE;
         endcase
      end
   end

   // Helper: consecutive high samples
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_r <= '0;
      end else if (!i_level) begin
         run_r <= '0;
      end else if (run_r != 32'hFFFF_FFFF) begin
         run_r <= run_r + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   a_fire_full_hold: assert property (
      o_fire |-> run_r >= WIN_CYC)
      else $error("preset fired without full hold");
   a_fire_once_only: assert property (
      o_fire |=> !o_fire [*8])
      else $error("preset fired twice in a row");
endmodule

module eps_core #(
   parameter int unsigned PRESET_CYC = `EPS_PRESET_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Register bus
   input wire eps_pkg::eps_avs_req_type i_avs,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Sensor
   input wire logic i_step,
   input wire logic i_step_cw,
   input wire logic signed [15:0] i_rpm,
   // Preset pins
   input wire logic i_preset1,
   input wire logic i_preset2,
   // Cyclic data to the fieldbus
   output logic [31:0] o_pos_word,
   output logic o_limit_bit,
   output logic [31:0] o_speed,
   output logic [7:0] o_diag_len,
   output logic [31:0] o_ssi_word,
   // Non-volatile store request
   output logic o_nv_store,
   output logic [31:0] o_nv_zero,
   output logic [31:0] o_nv_shift
);
   import eps_pkg::*;

   eps_ctrl_type ctrl_r;
   logic [31:0] len_r, num_r, den_r, pre1_r, pre2_r, limlo_r, limhi_r;
   logic [6:0] mult_r;
   logic refused_r, limit_r;
   logic [31:0] pos_r, raw_r;
   logic signed [31:0] shift_r;
   logic [47:0] frac_r, ipr_r, prod_r, step_r;
   logic [31:0] step_q_r;
   logic div_busy_r, div_pend_r;
   logic [5:0] div_cnt_r;
   logic [32:0] div_rem_r;
   logic [47:0] div_quo_r;
   logic fire1, fire2, wr_go, rd_go, wr_cfg, div_fin, fwd, stat_en;
   logic [31:0] eff_den, rd_val;
   logic [32:0] rem_t;
   logic [79:0] qd;
   logic [47:0] div_d, frac_sum, frac_nxt;
   logic carry;
   logic [32:0] add, pos_sum;
   logic [31:0] pos_nxt;

   // Two filters share one body
   eps_preset_filt #(.WIN_CYC(PRESET_CYC)) u_pf1 (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_level(i_preset1),
      .o_fire(fire1));
   eps_preset_filt #(.WIN_CYC(PRESET_CYC)) u_pf2 (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_level(i_preset2),
      .o_fire(fire2));

   // Offset that centres the used range in the next power of two
   function automatic logic [31:0] sh_off(input logic [31:0] len);
      logic [32:0] pw;
      pw = 33'h1_0000_0000;
      for (int i = 32; i >= 0; i--) begin
         if ((33'h0_0000_0001 << i) >= {1'b0, len}) begin
            pw = 33'h0_0000_0001 << i;
         end
      end
      return 32'((pw - {1'b0, len}) >> 1);
   endfunction

   function automatic logic [31:0] encode(input logic [31:0] b,
      input eps_code_type code, input logic [31:0] len);
      logic [31:0] t;
      t = b + sh_off(len);
      case (code)
         EPS_CODE_GRAY: return b ^ (b >> 1);
         EPS_CODE_SHGRAY: return t ^ (t >> 1);
         default: return b;
      endcase
   endfunction

   // Bus slave: one wait cycle, then answer
   assign wr_go = i_avs.write && !o_avs_waitrequest;
   assign rd_go = i_avs.read && o_avs_waitrequest;
   assign wr_cfg = wr_go && (i_avs.address == `EPS_REG_LEN ||
      i_avs.address == `EPS_REG_NUM || i_avs.address == `EPS_REG_DEN ||
      i_avs.address == `EPS_REG_CTRL);
   assign eff_den = ctrl_r.ext_mode ? den_r : 32'h0000_0001;
   assign stat_en = ctrl_r.commission != EPS_COMM_OFF_NOSTAT;
   assign fwd = i_step_cw ^ ctrl_r.ccw;

   always_comb begin
      case (i_avs.address)
         `EPS_REG_CTRL: rd_val = {17'h0_0000, ctrl_r};
         `EPS_REG_LEN: rd_val = len_r;
         `EPS_REG_NUM: rd_val = num_r;
         `EPS_REG_DEN: rd_val = den_r;
         `EPS_REG_PRE1: rd_val = pre1_r;
         `EPS_REG_PRE2: rd_val = pre2_r;
         `EPS_REG_LIMLO: rd_val = limlo_r;
         `EPS_REG_LIMHI: rd_val = limhi_r;
         `EPS_REG_MULT: rd_val = {25'h000_0000, mult_r};
         `EPS_REG_STAT: rd_val = {29'h0000_0000, refused_r, div_busy_r,
            limit_r};
         `EPS_REG_POS: rd_val = pos_r;
         `EPS_REG_IPR: rd_val = ipr_r[31:0];
         `EPS_REG_SHIFT: rd_val = shift_r;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= !((i_avs.read || i_avs.write) &&
            o_avs_waitrequest);
         if (rd_go) begin
            o_avs_readdata <= rd_val;
         end
      end
   end

   // Register writes; out-of-range values keep the old setting
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= `EPS_RST_CTRL;
         len_r <= `EPS_RST_LEN;
         num_r <= `EPS_RST_NUM;
         den_r <= `EPS_RST_DEN;
         pre1_r <= `EPS_RST_PRESET;
         pre2_r <= `EPS_RST_PRESET;
         limlo_r <= `EPS_RST_LIMLO;
         limhi_r <= `EPS_RST_LIMHI;
         mult_r <= `EPS_RST_MULT;
         refused_r <= 1'b0;
      end else if (wr_go) begin
         refused_r <= 1'b0;
         case (i_avs.address)
            `EPS_REG_CTRL: begin
               if (i_avs.writedata[1:0] == 2'h3 ||
                  i_avs.writedata[3:2] == 2'h3 ||
                  i_avs.writedata[8:7] != 2'h0 ||
                  i_avs.writedata[14:9] < `EPS_SSI_MIN ||
                  i_avs.writedata[14:9] > `EPS_SSI_MAX) begin
                  refused_r <= 1'b1;
               end else begin
                  ctrl_r <= eps_ctrl_type'(i_avs.writedata[14:0]);
               end
            end
            `EPS_REG_LEN: begin
               // Signed 32-bit: top bit set is negative
               if (i_avs.writedata[31] ||
                  i_avs.writedata < `EPS_LEN_MIN) begin
                  refused_r <= 1'b1;
               end else begin
                  len_r <= i_avs.writedata;
               end
            end
            `EPS_REG_NUM: begin
               if (i_avs.writedata[31] || i_avs.writedata == '0) begin
                  refused_r <= 1'b1;
               end else begin
                  num_r <= i_avs.writedata;
               end
            end
            `EPS_REG_DEN: begin
               if (i_avs.writedata > `EPS_DEN_MAX ||
                  i_avs.writedata == '0) begin
                  refused_r <= 1'b1;
               end else begin
                  den_r <= i_avs.writedata;
               end
            end
            `EPS_REG_PRE1: pre1_r <= i_avs.writedata;
            `EPS_REG_PRE2: pre2_r <= i_avs.writedata;
            `EPS_REG_LIMLO: limlo_r <= i_avs.writedata;
            `EPS_REG_LIMHI: limhi_r <= i_avs.writedata;
            `EPS_REG_MULT: begin
               if (i_avs.writedata > 32'(`EPS_MULT_MAX) ||
                  i_avs.writedata == '0) begin
                  refused_r <= 1'b1;
               end else begin
                  mult_r <= i_avs.writedata[6:0];
               end
            end
            default: refused_r <= 1'b0;
         endcase
      end
   end

   // Gear divider: ipr = len * den / num, 48 restoring steps
   assign rem_t = {div_rem_r[31:0], div_quo_r[47]};
   assign div_fin = div_busy_r && !div_pend_r && !wr_cfg &&
      div_cnt_r == 6'h01;
   assign div_d = {num_r[31:0], 16'h0000};
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_busy_r <= 1'b1;
         div_pend_r <= 1'b1;
         div_cnt_r <= 6'h00;
         div_rem_r <= '0;
         div_quo_r <= '0;
         prod_r <= '0;
      end else if (wr_cfg) begin
         div_busy_r <= 1'b1;
         div_pend_r <= 1'b1;
      end else if (div_pend_r) begin
         div_pend_r <= 1'b0;
         prod_r <= 48'(len_r * eff_den);
         div_quo_r <= 48'(len_r * eff_den);
         div_rem_r <= '0;
         div_cnt_r <= 6'h30;
      end else if (div_busy_r) begin
         if (rem_t >= {1'b0, num_r}) begin
            div_rem_r <= rem_t - {1'b0, num_r};
            div_quo_r <= {div_quo_r[46:0], 1'b1};
         end else begin
            div_rem_r <= rem_t;
            div_quo_r <= {div_quo_r[46:0], 1'b0};
         end
         div_cnt_r <= div_cnt_r - 6'h01;
         if (div_cnt_r == 6'h01) begin
            div_busy_r <= 1'b0;
         end
      end
   end

   // Per raw step the position advances by prod/(num*65536) increments
   always_comb begin
      qd = 80'({div_quo_r[46:0], rem_t >= {1'b0, num_r}} >> 16);
      qd = qd * {32'h0000_0000, div_d};
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ipr_r <= '0;
         step_q_r <= '0;
         step_r <= '0;
      end else if (div_fin) begin
         ipr_r <= {div_quo_r[46:0], rem_t >= {1'b0, num_r}};
         step_q_r <= 32'({div_quo_r[46:0], rem_t >= {1'b0, num_r}} >> 16);
         step_r <= prod_r - qd[47:0];
      end
   end

   // Fraction accumulator keeps fractional gears exact
   always_comb begin
      frac_sum = frac_r + step_r;
      if (fwd) begin
         carry = frac_sum >= div_d;
         frac_nxt = carry ? frac_sum - div_d : frac_sum;
      end else begin
         carry = frac_r < step_r;
         frac_nxt = carry ? frac_r + div_d - step_r : frac_r - step_r;
      end
      add = {1'b0, step_q_r} + {32'h0000_0000, carry};
      pos_sum = {1'b0, pos_r} + add;
      if (fwd) begin
         pos_nxt = pos_sum >= {1'b0, len_r} ?
            32'(pos_sum - {1'b0, len_r}) : pos_sum[31:0];
      end else if ({1'b0, pos_r} >= add) begin
         pos_nxt = 32'({1'b0, pos_r} - add);
      end else begin
         pos_nxt = 32'({1'b0, pos_r} + {1'b0, len_r} - add);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_r <= '0;
         frac_r <= '0;
      end else if (fire1) begin
         pos_r <= pre1_r < len_r ? pre1_r : '0;
         frac_r <= '0;
      end else if (fire2) begin
         pos_r <= pre2_r < len_r ? pre2_r : '0;
         frac_r <= '0;
      end else if (div_fin) begin
         if (pos_r >= len_r) begin
            pos_r <= '0;
         end
         frac_r <= '0;
      end else if (i_step) begin
         pos_r <= pos_nxt;
         frac_r <= frac_nxt;
      end
   end

   // Raw span is 65536 turns; a wrap shifts the zero mark when the
   // revolution count does not divide it
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         raw_r <= '0;
         shift_r <= '0;
         o_nv_store <= 1'b0;
         o_nv_zero <= '0;
         o_nv_shift <= '0;
      end else begin
         o_nv_store <= 1'b0;
         if (i_step) begin
            raw_r <= fwd ? raw_r + 32'h0000_0001 : raw_r - 32'h0000_0001;
            if ((fwd ? raw_r == 32'hFFFF_FFFF : raw_r == '0) &&
               (eff_den != 32'h0000_0001 ||
               (num_r & (num_r - 32'h0000_0001)) != '0 ||
               num_r > `EPS_RAW_TURNS)) begin
               shift_r <= fwd ? shift_r + 32'sh0000_0001 :
                  shift_r - 32'sh0000_0001;
               o_nv_store <= 1'b1;
               o_nv_zero <= pos_nxt;
               o_nv_shift <= fwd ? shift_r + 32'sh0000_0001 :
                  shift_r - 32'sh0000_0001;
            end
         end
      end
   end

   // Equal to a limit counts as outside
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         limit_r <= 1'b1;
         o_limit_bit <= 1'b0;
      end else begin
         limit_r <= !(limlo_r < pos_r &&
            pos_r < limhi_r);
         o_limit_bit <= stat_en && limit_r;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pos_word <= '0;
         o_ssi_word <= '0;
         o_speed <= '0;
         o_diag_len <= `EPS_DIAG_LONG;
      end else begin
         o_pos_word <= encode(pos_r, ctrl_r.bus_code, len_r);
         o_ssi_word <= encode(pos_r, ctrl_r.ssi_code, len_r) <<
            (6'h20 - ctrl_r.ssi_bits);
         o_speed <= 32'(i_rpm * $signed({1'b0, mult_r}));
         o_diag_len <= ctrl_r.ext_mode && ctrl_r.short_diag ?
            `EPS_DIAG_SHORT : `EPS_DIAG_LONG;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   a_limit_inside_clear: assert property (
      (limlo_r < pos_r && pos_r < limhi_r) |=> !limit_r)
      else $error("limit bit set inside window");
   a_limit_outside_set: assert property (
      (pos_r < limlo_r || pos_r > limhi_r) |=> limit_r)
      else $error("limit bit clear outside window");
   a_limit_edge_set: assert property (
      (pos_r == limlo_r || pos_r == limhi_r) |=> limit_r)
      else $error("limit bit clear on a limit");
   a_limit_report_gate: assert property (
      !stat_en |=> !o_limit_bit)
      else $error("limit bit reported without status");
   a_gray_code_out: assert property (
      ctrl_r.bus_code == EPS_CODE_GRAY |=>
      o_pos_word == ($past(pos_r) ^ ($past(pos_r) >> 1)))
      else $error("gray position word wrong");
   a_preset1_load: assert property (
      fire1 && pre1_r < len_r |=> pos_r == $past(pre1_r))
      else $error("preset one not loaded");
   a_preset2_load: assert property (
      fire2 && !fire1 && pre2_r < len_r |=> pos_r == $past(pre2_r))
      else $error("preset two not loaded");
   a_speed_scaled: assert property (
      ##1 o_speed == 32'($past(i_rpm) * $signed({1'b0, $past(mult_r)})))
      else $error("speed not scaled");
   a_diag_short: assert property (
      ctrl_r.ext_mode && ctrl_r.short_diag |=> o_diag_len == 8'h10)
      else $error("short diagnostics length wrong");
   a_pos_in_range: assert property (
      !div_busy_r && !$past(div_busy_r) |-> pos_r < len_r)
      else $error("position beyond measuring length");
   a_den_refused: assert property (
      wr_go && i_avs.address == `EPS_REG_DEN &&
      i_avs.writedata > `EPS_DEN_MAX |=> den_r == $past(den_r))
      else $error("oversize denominator accepted");

   c_preset_fire: cover property (fire1);
   c_limit_out: cover property (stat_en && limit_r);
   c_div_done: cover property (div_fin);
   c_nv_store: cover property (o_nv_store);
endmodule
`default_nettype wire
